/* logic/ddl_pkg.sv */
package ddl_pkg;
   // pin-side timing, in ns, and derived cycle counts at 100 MHz
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SETUP_NS = 30;
   localparam int T_WRITE_NS = 50;
   localparam int T_LOAD_NS = 50;
   localparam int T_HOLD_NS = 10;
   localparam int T_SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_WRITE_CYC = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_LOAD_CYC = (T_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // field layout of a 12-bit word split into bytes
   localparam int WORD_W = 12;
   localparam int BYTE_W = 8;
   localparam int HI_W = 4;
   localparam int CNT_W = 4;
   // latch address codes on the byte-wide variant
   localparam logic [1:0] ADDR_A_LO = 2'h0;
   localparam logic [1:0] ADDR_A_HI = 2'h1;
   localparam logic [1:0] ADDR_B_LO = 2'h2;
   localparam logic [1:0] ADDR_B_HI = 2'h3;
   typedef enum logic {DDL_PAR, DDL_BYTE} ddl_variant_t;
endpackage

/* logic/ddl_timer_if.sv */
interface ddl_timer_if;
   import ddl_pkg::*;
   logic start;
   logic [CNT_W-1:0] len;
   logic done;
   modport owner (output start, output len, input done);
   modport timer (input start, input len, output done);
endinterface

/* logic/ddl_timer.sv */
module ddl_timer
   import ddl_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   ddl_timer_if.timer t
);
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic run_q, run_d;

   // load on start, count down to one, then flag done
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      if (t.start) begin
         cnt_d = t.len;
         run_d = 1'b1;
      end else if (run_q) begin
         if (cnt_q <= CNT_W'(1)) run_d = 1'b0;
         else cnt_d = cnt_q - CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end

   // single-cycle pulse as the last counted cycle ends; built from flops
   // only, since the owner restarts on done and must not loop back into it
   assign t.done = run_q && (cnt_q <= CNT_W'(1));
endmodule

/* logic/ddl_host.sv */
// Overview of operation
// - load strobe stays low a full pulse width after write ends
// - byte part: four latch writes plus one load, two writes a word
// - latch address comes from the channel and byte phase; high nibble right-justified
// - parallel part: full word to one or both channels in a single write
module ddl_host
   import ddl_pkg::*;
#(
   parameter ddl_variant_t VARIANT = DDL_BYTE
)(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_chan_b,
   input wire logic req_both,
   input wire logic req_load,
   input wire logic [WORD_W-1:0] req_data,
   output logic done,
   output logic [WORD_W-1:0] dac_data,
   output logic chan_a_select_n,
   output logic chan_b_select_n,
   output logic cs_n,
   output logic wr_n,
   output logic latch_addr_lo,
   output logic latch_addr_hi,
   output logic load_outputs_n
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_LOAD
   } ddl_state_t;

   ddl_timer_if tif ();
   ddl_timer u_tmr (.core_clk(core_clk), .nrst(nrst), .t(tif));

   ddl_state_t st_q, st_d;
   logic [WORD_W-1:0] word_q, word_d;
   logic [WORD_W-1:0] dout_q, dout_d;
   logic [1:0] addr_q, addr_d;
   logic sel_a_q, sel_a_d, sel_b_q, sel_b_d;
   logic cs_q, cs_d, wr_q, wr_d, ld_q, ld_d;
   logic second_q, second_d, done_q, done_d;

   // byte for the given phase: low byte, or high nibble right-justified
   function automatic logic [WORD_W-1:0] pick(input logic [WORD_W-1:0] w,
                                              input logic hi);
      if (hi) pick = {{BYTE_W{1'b0}}, w[WORD_W-1:BYTE_W]};
      else pick = {{HI_W{1'b0}}, w[BYTE_W-1:0]};
   endfunction

   // latch address for a channel and byte half
   function automatic logic [1:0] addr_of(input logic b, input logic hi);
      addr_of = b ? (hi ? ADDR_B_HI : ADDR_B_LO)
                  : (hi ? ADDR_A_HI : ADDR_A_LO);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // write sequencer
   always_comb begin
      st_d = st_q;
      word_d = word_q;
      dout_d = dout_q;
      addr_d = addr_q;
      sel_a_d = sel_a_q;
      sel_b_d = sel_b_q;
      cs_d = cs_q;
      wr_d = wr_q;
      ld_d = ld_q;
      second_d = second_q;
      done_d = 1'b0;
      tif.start = 1'b0;
      tif.len = CNT_W'(T_SETUP_CYC);
      unique case (st_q)
         ST_IDLE: begin
            if (req_valid) begin
               word_d = req_data;
               second_d = 1'b0;
               tif.start = 1'b1;
               if (VARIANT == DDL_BYTE && req_load) begin
                  // load-only: pulse the shared strobe, no write cycle
                  ld_d = 1'b0;
                  tif.len = CNT_W'(T_LOAD_CYC);
                  st_d = ST_LOAD;
               end else begin
                  if (VARIANT == DDL_PAR) begin
                     // one full-width write, with one or both channel selects low
                     dout_d = req_data;
                     sel_a_d = req_both || !req_chan_b;
                     sel_b_d = req_both || req_chan_b;
                  end else begin
                     // low byte first here; the part takes either order
                     dout_d = pick(req_data, 1'b0);
                     addr_d = addr_of(req_chan_b, 1'b0);
                     cs_d = 1'b1;
                  end
                  st_d = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            // data and address settle before the strobe drops
            if (tif.done) begin
               wr_d = 1'b1;
               tif.start = 1'b1;
               tif.len = CNT_W'(T_WRITE_CYC);
               st_d = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (tif.done) begin
               // rising strobe edge captures the word
               wr_d = 1'b0;
               tif.start = 1'b1;
               tif.len = CNT_W'(T_HOLD_CYC);
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (tif.done) begin
               sel_a_d = 1'b0;
               sel_b_d = 1'b0;
               cs_d = 1'b0;
               if (VARIANT == DDL_BYTE && !second_q) begin
                  // second write carries the high nibble
                  second_d = 1'b1;
                  dout_d = pick(word_q, 1'b1);
                  // channel of the word in flight: first byte's address
                  addr_d = addr_of(addr_q[1], 1'b1);
                  cs_d = 1'b1;
                  tif.start = 1'b1;
                  st_d = ST_SETUP;
               end else begin
                  done_d = 1'b1;
                  st_d = ST_IDLE;
               end
            end
         end
         ST_LOAD: begin
            // strobe low a full pulse width, clear of any write
            if (tif.done) begin
               ld_d = 1'b1;
               done_d = 1'b1;
               st_d = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         word_q <= '0;
         dout_q <= '0;
         addr_q <= ADDR_A_LO;
         sel_a_q <= 1'b0;
         sel_b_q <= 1'b0;
         cs_q <= 1'b0;
         wr_q <= 1'b0;
         ld_q <= 1'b1;
         second_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         word_q <= word_d;
         dout_q <= dout_d;
         addr_q <= addr_d;
         sel_a_q <= sel_a_d;
         sel_b_q <= sel_b_d;
         cs_q <= cs_d;
         wr_q <= wr_d;
         ld_q <= ld_d;
         second_q <= second_d;
         done_q <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pins: active-low strobes come straight from flops, no glitches
   assign req_ready = (st_q == ST_IDLE);
   assign done = done_q;
   assign dac_data = dout_q;
   assign chan_a_select_n = !sel_a_q;
   assign chan_b_select_n = !sel_b_q;
   assign cs_n = !cs_q;
   assign wr_n = !wr_q;
   assign latch_addr_lo = addr_q[0];
   assign latch_addr_hi = addr_q[1];
   assign load_outputs_n = ld_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_wr_sel;
      @(posedge core_clk) disable iff (!nrst)
         !wr_n |-> (VARIANT == DDL_PAR ? !(chan_a_select_n && chan_b_select_n)
                                       : !cs_n);
   endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");

   property p_no_overlap;
      @(posedge core_clk) disable iff (!nrst)
         !load_outputs_n |-> wr_n && cs_n;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("load in write");

   property p_load_width;
      @(posedge core_clk) disable iff (!nrst)
         $fell(load_outputs_n) |-> !load_outputs_n [*5];
   endproperty
   a_load_width: assert property (p_load_width) else $error("load short");

   property p_stable_data;
      @(posedge core_clk) disable iff (!nrst)
         !wr_n |-> $stable(dac_data) && $stable(latch_addr_lo)
                   && $stable(latch_addr_hi);
   endproperty
   a_stable_data: assert property (p_stable_data) else $error("data moved");

   property p_hi_nibble;
      @(posedge core_clk) disable iff (!nrst)
         (VARIANT == DDL_BYTE && !wr_n && latch_addr_lo) |->
            dac_data[WORD_W-1:HI_W] == '0;
   endproperty
   a_hi_nibble: assert property (p_hi_nibble) else $error("nibble");
endmodule

/* bench/ddl_dac_model.sv */
// behavioural byte-wide dual converter: input latches, then output latches
module ddl_dac_model
   import ddl_pkg::*;
(
   input wire logic [BYTE_W-1:0] data,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic latch_addr_lo,
   input wire logic latch_addr_hi,
   input wire logic load_outputs_n,
   output logic [WORD_W-1:0] out_a,
   output logic [WORD_W-1:0] out_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [BYTE_W-1:0] a_lo = 8'h00;
   logic [BYTE_W-1:0] b_lo = 8'h00;
   logic [HI_W-1:0] a_hi = 4'h0;
   logic [HI_W-1:0] b_hi = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // level latches: a selected part follows its pins while the strobe is low
   // input parts load in any order, each on its own address
   always @* begin
      if (!cs_n && !wr_n) begin
         case ({latch_addr_hi, latch_addr_lo})
            2'h0: a_lo = data;
            2'h1: a_hi = data[HI_W-1:0];
            2'h2: b_lo = data;
            default: b_hi = data[HI_W-1:0];
         endcase
      end
      // outputs only move through the load strobe, never on writes
      if (!load_outputs_n) begin
         out_a = {a_hi, a_lo};
         out_b = {b_hi, b_lo};
      end
   end

   // outputs start at zero, as if cleared before the first load
   initial begin
      out_a = 12'h000;
      out_b = 12'h000;
   end
endmodule

////////////////////////////////////////////////////////////////////////
// behavioural parallel dual converter: one level latch per channel
module ddl_par_model
   import ddl_pkg::*;
(
   input wire logic [WORD_W-1:0] data,
   input wire logic chan_a_select_n,
   input wire logic chan_b_select_n,
   input wire logic wr_n,
   output logic [WORD_W-1:0] out_a,
   output logic [WORD_W-1:0] out_b
);
   timeunit 1ns;
   timeprecision 1ps;

   // a selected latch follows while the strobe is low, keeps on its rise;
   // both selects low load the same word into both latches
   always @* begin
      if (!wr_n && !chan_a_select_n)
         out_a = data;
      if (!wr_n && !chan_b_select_n)
         out_b = data;
   end

   // latches start at zero, as if cleared at power-up
   initial begin
      out_a = 12'h000;
      out_b = 12'h000;
   end
endmodule

/* bench/ddl_host_tb.sv */
module ddl_host_tb
   import ddl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic req_chan_b = 1'b0;
   logic req_load = 1'b0;
   logic [WORD_W-1:0] req_data = 12'h000;
   logic req_ready, done, cs_n, wr_n, latch_addr_lo, latch_addr_hi;
   logic load_outputs_n;
   logic [WORD_W-1:0] dac_data, out_a, out_b;
   logic [WORD_W-1:0] in_a = 12'h000, in_b = 12'h000;
   logic [WORD_W-1:0] exp_a = 12'h000, exp_b = 12'h000;
   logic [2*WORD_W-1:0] exp_q[$];
   int n_errors = 0;
   int total_checks = 0;
   int seed = 58;
   int r;
   // second instance in the parallel variant, with its own notes
   logic par_valid = 1'b0;
   logic par_both = 1'b0;
   logic par_ready, par_done, par_sel_a_n, par_sel_b_n, par_wr_n;
   logic [WORD_W-1:0] par_data, par_a, par_b;
   logic [WORD_W-1:0] pa_exp_a = 12'h000, pa_exp_b = 12'h000;
   logic [2*WORD_W-1:0] par_q[$];

   always #5 core_clk = ~core_clk;

   ddl_host #(.VARIANT(DDL_BYTE)) ddl_host_i (.core_clk(core_clk),
      .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
      .req_chan_b(req_chan_b), .req_both(1'b0), .req_load(req_load),
      .req_data(req_data), .done(done), .dac_data(dac_data),
      .chan_a_select_n(), .chan_b_select_n(), .cs_n(cs_n), .wr_n(wr_n),
      .latch_addr_lo(latch_addr_lo), .latch_addr_hi(latch_addr_hi),
      .load_outputs_n(load_outputs_n));

   ddl_dac_model ddl_dac_model_i (.data(dac_data[BYTE_W-1:0]), .cs_n(cs_n),
      .wr_n(wr_n), .latch_addr_lo(latch_addr_lo),
      .latch_addr_hi(latch_addr_hi), .load_outputs_n(load_outputs_n),
      .out_a(out_a), .out_b(out_b));

   // parallel variant: load strobe and byte pins have no use here
   ddl_host #(.VARIANT(DDL_PAR)) ddl_host_par_i (.core_clk(core_clk),
      .nrst(nrst), .req_valid(par_valid), .req_ready(par_ready),
      .req_chan_b(req_chan_b), .req_both(par_both), .req_load(1'b0),
      .req_data(req_data), .done(par_done), .dac_data(par_data),
      .chan_a_select_n(par_sel_a_n), .chan_b_select_n(par_sel_b_n),
      .cs_n(), .wr_n(par_wr_n), .latch_addr_lo(), .latch_addr_hi(),
      .load_outputs_n());

   ddl_par_model ddl_par_model_i (.data(par_data),
      .chan_a_select_n(par_sel_a_n), .chan_b_select_n(par_sel_b_n),
      .wr_n(par_wr_n), .out_a(par_a), .out_b(par_b));

   ////////////////////////////////////////////////////////////////////////
   task check(input logic [2*WORD_W-1:0] got, input logic [2*WORD_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t outputs %h expected %h", $time, got, exp);
      end
   endtask

   task finish_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // one request; the note of what the outputs must show goes in the queue
   task send(input logic chan_b, input logic load, input logic [11:0] data);
      int n;
      if (load) begin
         exp_a = in_a;
         exp_b = in_b;
      end else if (chan_b)
         in_b = data;
      else
         in_a = data;
      exp_q.push_back({exp_a, exp_b});
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_chan_b <= chan_b;
      req_load <= load;
      req_data <= data;
      @(negedge core_clk);
      check({23'h0, req_ready}, 24'h1);
      @(posedge core_clk);
      req_valid <= 1'b0;
      // bounded wait: a lost done must not hang the run
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (done !== 1'b1 && n < 200);
      check({23'h0, done}, 24'h1);
   endtask

   // parallel part: one full-width write per request, no load strobe
   task send_par(input logic chan_b, input logic both,
                 input logic [WORD_W-1:0] data);
      int n;
      if (both || !chan_b)
         pa_exp_a = data;
      if (both || chan_b)
         pa_exp_b = data;
      par_q.push_back({pa_exp_a, pa_exp_b});
      @(posedge core_clk);
      par_valid <= 1'b1;
      req_chan_b <= chan_b;
      par_both <= both;
      req_data <= data;
      @(negedge core_clk);
      check({23'h0, par_ready}, 24'h1);
      @(posedge core_clk);
      par_valid <= 1'b0;
      // bounded wait, as for the byte part
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (par_done !== 1'b1 && n < 200);
      check({23'h0, par_done}, 24'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // monitor: each done takes the oldest note and compares both outputs
   always @(negedge core_clk) begin
      if (done === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("[ERR] %0t done with no request noted", $time);
         end else
            check({out_a, out_b}, exp_q.pop_front());
      end
      if (par_done === 1'b1) begin
         if (par_q.size() == 0) begin
            n_errors++;
            $display("[ERR] %0t parallel done with no request", $time);
         end else
            check({par_a, par_b}, par_q.pop_front());
      end
   end

   // watchdog, far beyond some forty requests of a few dozen cycles
   initial begin
      #200000;
      n_errors++;
      finish_test();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      @(negedge core_clk);
      check({20'h0, cs_n, load_outputs_n, par_sel_a_n, par_sel_b_n},
            24'hF);
      send(1'b0, 1'b0, 12'hABC);
      send(1'b1, 1'b0, 12'h5F3);
      send(1'b0, 1'b1, 12'h9A5);
      send(1'b1, 1'b0, 12'hFFF);
      send(1'b0, 1'b0, 12'h000);
      send(1'b0, 1'b1, 12'h000);
      send(1'b0, 1'b1, 12'h3C3);
      // random channels, words and loads; data on a load must be ignored
      for (int i = 0; i < 20; i++) begin
         r = $random(seed);
         send(r[0], r[3:1] == 3'h0, r[15:4]);
      end
      send(1'b1, 1'b1, 12'h000);
      // parallel part: each channel alone, both at once, then random
      send_par(1'b0, 1'b0, 12'hABC);
      send_par(1'b1, 1'b0, 12'h5F3);
      send_par(1'b0, 1'b1, 12'h9A5);
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         send_par(r[0], r[1], r[15:4]);
      end
      finish_test();
   end
endmodule
